//--- core/register_space_address_decoder.v
// Register space and paged flash window decoder with part ID registers.
// Assumes the requesting master holds address and strobes stable for one
// bus cycle, and that each peripheral returns its read data combinationally.
`include "register_space_decoder_map.vh"

module register_space_address_decoder #(
    parameter LARGE_FLASH = 1,
    // Arbitrary neutral identification value
    parameter [15:0] PART_ID = 16'h0A5C
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Access from core or background debug master
    input wire [15:0] addr_in,
    input wire read_in,
    input wire write_in,
    input wire [7:0] wdata_in,
    input wire [7:0] flash_page_select_in,
    output wire [7:0] rdata_out,
    // Module selects
    output wire [`SEL_COUNT-1:0] select_out,
    output wire periph_write_out,
    output wire periph_read_out,
    output wire [7:0] periph_wdata_out,
    input wire [8*`SEL_COUNT-1:0] periph_rdata_in,
    // Paged flash access
    output wire [17:0] global_addr_out,
    output wire page_missing_out,
    output reg [7:0] last_read_out
);

////////////////////////////////////////////////////////////////////////////////

function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
        in_range = (a >= lo) && (a <= hi);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

// Raw range hits, one per range of the map
// Port integration and memory map control
wire hit_port_a;
assign hit_port_a =
    in_range(addr_in, `PORT_A_LO, `PORT_A_HI);
wire hit_port_b;
assign hit_port_b =
    in_range(addr_in, `PORT_B_LO, `PORT_B_HI);
wire hit_port_c;
assign hit_port_c =
    in_range(addr_in, `PORT_C_LO, `PORT_C_HI);
wire hit_port_d;
assign hit_port_d =
    in_range(addr_in, `PORT_D_LO, `PORT_D_HI);
wire hit_mmc_a;
assign hit_mmc_a =
    in_range(addr_in, `MMC_A_LO, `MMC_A_HI);
wire hit_mmc_b;
assign hit_mmc_b =
    in_range(addr_in, `MMC_B_LO, `MMC_B_HI);

// Part identification and debug
wire hit_part_id;
assign hit_part_id =
    (addr_in == `PART_ID_HIGH_ADDR) || (addr_in == `PART_ID_LOW_ADDR);
wire hit_debug;
assign hit_debug =
    in_range(addr_in, `DEBUG_LO, `DEBUG_HI);

// Clock and power unit
wire hit_cpu_a;
assign hit_cpu_a =
    in_range(addr_in, `CPU_A_LO, `CPU_A_HI);
wire hit_cpu_b;
assign hit_cpu_b =
    in_range(addr_in, `CPU_B_LO, `CPU_B_HI);

// Timer, converter and modulator
wire hit_timer;
assign hit_timer =
    in_range(addr_in, `TIMER_LO, `TIMER_HI);
wire hit_adc;
assign hit_adc =
    in_range(addr_in, `ADC_LO, `ADC_HI);
wire hit_pwm;
assign hit_pwm =
    in_range(addr_in, `PWM_LO, `PWM_HI);

// Serial interfaces
wire hit_ser0;
assign hit_ser0 =
    in_range(addr_in, `SER0_LO, `SER0_HI);
wire hit_ser1;
assign hit_ser1 =
    in_range(addr_in, `SER1_LO, `SER1_HI);
wire hit_spi;
assign hit_spi =
    in_range(addr_in, `SPI_LO, `SPI_HI);

// Flash control and interrupt
wire hit_flash_ctl;
assign hit_flash_ctl =
    in_range(addr_in, `FLASH_CTL_LO, `FLASH_CTL_HI);
wire hit_intr;
assign hit_intr =
    (addr_in == `INTR_ADDR);

// Drivers, transceiver and supply sense
wire hit_hsd;
assign hit_hsd =
    in_range(addr_in, `HSD_LO, `HSD_HI);
wire hit_lsd;
assign hit_lsd =
    in_range(addr_in, `LSD_LO, `LSD_HI);
wire hit_lin;
assign hit_lin =
    in_range(addr_in, `LIN_LO, `LIN_HI);
wire hit_supply;
assign hit_supply =
    in_range(addr_in, `SUPPLY_LO, `SUPPLY_HI);

// Flash window and whole register space
wire hit_window;
assign hit_window =
    in_range(addr_in, `WINDOW_LO, `WINDOW_HI);
wire hit_reg_space;
assign hit_reg_space =
    (addr_in <= `REG_SPACE_TOP);

////////////////////////////////////////////////////////////////////////////////

wire [`SEL_COUNT-1:0] hit;
wire [`SEL_COUNT-1:0] sel;
wire [`SEL_COUNT:0] taken;
wire access = read_in | write_in;

assign hit[`SEL_PORT] = hit_port_a | hit_port_b | hit_port_c | hit_port_d;
assign hit[`SEL_MMC] = hit_mmc_a | hit_mmc_b;
assign hit[`SEL_PART_ID] = hit_part_id;
assign hit[`SEL_DEBUG] = hit_debug;
assign hit[`SEL_CPU] = hit_cpu_a | hit_cpu_b;
assign hit[`SEL_TIMER] = hit_timer;
assign hit[`SEL_ADC] = hit_adc;
assign hit[`SEL_PWM] = hit_pwm;
assign hit[`SEL_SER0] = hit_ser0;
assign hit[`SEL_SER1] = hit_ser1;
assign hit[`SEL_SPI] = hit_spi;
assign hit[`SEL_FLASH_CTL] = hit_flash_ctl;
assign hit[`SEL_INTR] = hit_intr;
assign hit[`SEL_HSD] = hit_hsd;
assign hit[`SEL_LSD] = hit_lsd;
assign hit[`SEL_LIN] = hit_lin;
assign hit[`SEL_SUPPLY] = hit_supply;
assign hit[`SEL_FLASH_WIN] = hit_window;
// Reserved is the catch-all of the register space, so it must stay last
assign hit[`SEL_RESERVED] = hit_reg_space;

// First hit in index order wins, keeping selects one-hot if ranges ever overlap
assign taken[0] = 1'b0;
genvar k;
generate
    for (k = 0; k < `SEL_COUNT; k = k + 1) begin : g_prio
        assign sel[k] = hit[k] & ~taken[k];
        assign taken[k + 1] = taken[k] | hit[k];
    end
endgenerate

assign select_out = access ? sel : {`SEL_COUNT{1'b0}};

////////////////////////////////////////////////////////////////////////////////

// Page 0xC is absent in the smaller part; accesses there are flagged, writes are blocked and reads return zero
wire page_absent = (LARGE_FLASH == 0) && (flash_page_select_in == `UNPOP_PAGE);
assign page_missing_out = access && sel[`SEL_FLASH_WIN] && page_absent;
assign global_addr_out = {flash_page_select_in[3:0], addr_in[13:0]};

// Reserved and part ID addresses never pass a write strobe to any module
wire no_write = sel[`SEL_RESERVED] | sel[`SEL_PART_ID] | (sel[`SEL_FLASH_WIN] & page_absent);
assign periph_write_out = write_in & ~no_write;
assign periph_read_out = read_in & ~sel[`SEL_RESERVED];
assign periph_wdata_out = wdata_in;

////////////////////////////////////////////////////////////////////////////////

// Read data is an OR over selected modules; id and reserved never take a module byte
wire [7:0] or_chain [0:`SEL_COUNT];
assign or_chain[0] = 8'h00;
generate
    for (k = 0; k < `SEL_COUNT; k = k + 1) begin : g_rmux
        wire pass = sel[k] && (k != `SEL_PART_ID) && (k != `SEL_RESERVED);
        assign or_chain[k + 1] = or_chain[k] | (pass ? periph_rdata_in[8*k +: 8] : 8'h00);
    end
endgenerate

reg [7:0] id_byte;

always @* begin
    id_byte = 8'h00;
    case (addr_in)
        `PART_ID_HIGH_ADDR: begin
            id_byte = PART_ID[15:8];
        end
        `PART_ID_LOW_ADDR: begin
            id_byte = PART_ID[7:0];
        end
        default: begin
            id_byte = 8'h00;
        end
    endcase
end

reg [7:0] mux_data;

always @* begin
    mux_data = or_chain[`SEL_COUNT];
    if (sel[`SEL_PART_ID])
        mux_data = id_byte;
    if (sel[`SEL_FLASH_WIN] && page_absent)
        mux_data = 8'h00;
end

assign rdata_out = read_in ? mux_data : 8'h00;

// Captured read data for observation by the debug side
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
        last_read_out <= 8'h00;
    else if (read_in)
        last_read_out <= mux_data;
end

endmodule

//--- core/register_space_decoder_map.vh
// Address map constants for the register space decoder.
// Assumes a 16-bit local address bus and 8-bit data, one clock domain.
//
// Notes on behaviour
// - Port integration select for 0x0000-0x0009, 0x000C-0x000D, 0x001C-0x001F, 0x0240-0x027F.
// - Memory map control select for 0x000A-0x000B and 0x0010-0x0017.
// - Clock and power unit select for 0x0034-0x003F and 0x02F0-0x02FF.
// - Timer gets 0x0040-0x006F, converter gets 0x0070-0x009F.
// - Pulse-width modulator gets 0x00A0-0x00C7.
// - First async serial 0x00C8-0x00CF, second 0x00D0-0x00D7.
// - Synchronous serial interface gets 0x00D8-0x00DF.
// - High-side 0x0140, low-side 0x0150, LIN transceiver 0x0160, eight bytes each.
// - Supply sense select for 0x0170-0x0177.
// - Writes to reserved space are dropped and change nothing.
// - Reads from reserved space return zero.
// - Local 0x8000-0xBFFF maps into 256K global space via the flash page.
// - Flash page 0xC exists only in the larger-flash variant.
// - Two read-only part ID bytes at 0x001A and 0x001B; writes ignored.
`ifndef REGISTER_SPACE_DECODER_MAP_VH
`define REGISTER_SPACE_DECODER_MAP_VH
`define REG_SPACE_TOP 16'h03FF
`define PORT_A_LO 16'h0000
`define PORT_A_HI 16'h0009
`define MMC_A_LO 16'h000A
`define MMC_A_HI 16'h000B
`define PORT_B_LO 16'h000C
`define PORT_B_HI 16'h000D
`define MMC_B_LO 16'h0010
`define MMC_B_HI 16'h0017
`define PART_ID_HIGH_ADDR 16'h001A
`define PART_ID_LOW_ADDR 16'h001B
`define PORT_C_LO 16'h001C
`define PORT_C_HI 16'h001F
`define DEBUG_LO 16'h0020
`define DEBUG_HI 16'h002F
`define CPU_A_LO 16'h0034
`define CPU_A_HI 16'h003F
`define TIMER_LO 16'h0040
`define TIMER_HI 16'h006F
`define ADC_LO 16'h0070
`define ADC_HI 16'h009F
`define PWM_LO 16'h00A0
`define PWM_HI 16'h00C7
`define SER0_LO 16'h00C8
`define SER0_HI 16'h00CF
`define SER1_LO 16'h00D0
`define SER1_HI 16'h00D7
`define SPI_LO 16'h00D8
`define SPI_HI 16'h00DF
`define FLASH_CTL_LO 16'h0100
`define FLASH_CTL_HI 16'h0113
`define INTR_ADDR 16'h0120
`define HSD_LO 16'h0140
`define HSD_HI 16'h0147
`define LSD_LO 16'h0150
`define LSD_HI 16'h0157
`define LIN_LO 16'h0160
`define LIN_HI 16'h0167
`define SUPPLY_LO 16'h0170
`define SUPPLY_HI 16'h0177
`define PORT_D_LO 16'h0240
`define PORT_D_HI 16'h027F
`define CPU_B_LO 16'h02F0
`define CPU_B_HI 16'h02FF
`define WINDOW_LO 16'h8000
`define WINDOW_HI 16'hBFFF
`define UNPOP_PAGE 8'h0C
`define SEL_COUNT 19
`define SEL_PORT 0
`define SEL_MMC 1
`define SEL_PART_ID 2
`define SEL_DEBUG 3
`define SEL_CPU 4
`define SEL_TIMER 5
`define SEL_ADC 6
`define SEL_PWM 7
`define SEL_SER0 8
`define SEL_SER1 9
`define SEL_SPI 10
`define SEL_FLASH_CTL 11
`define SEL_INTR 12
`define SEL_HSD 13
`define SEL_LSD 14
`define SEL_LIN 15
`define SEL_SUPPLY 16
`define SEL_FLASH_WIN 17
`define SEL_RESERVED 18
`endif

//--- tb/decoder_checker.sv
// Port-level assertions for the register space decoder.
// Assumes one clock domain and an active high asynchronous reset.
module decoder_checker #(parameter LARGE_FLASH = 1) (
    // Decoder ports, grouped by width to keep the file short
    input wire logic clk_in, rst_in, read_in, write_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] flash_page_select_in, rdata_out, last_read_out,
    input wire logic [18:0] select_out,
    input wire logic [17:0] global_addr_out,
    input wire logic periph_write_out, page_missing_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    wire win = addr_in[15:14] == 2'b10 && (read_in || write_in);
    ////////////////////////////////////////////////////////////////////////////
    a_one_select: assert property ($onehot0(select_out))
        else $error("more than one select");
    a_idle_no_select: assert property (!(read_in || write_in) |-> select_out == 0)
        else $error("select without strobe");
    a_reserved_read_zero: assert property (read_in && select_out[18] |-> rdata_out == 0)
        else $error("reserved read not zero");
    a_reserved_write_drop: assert property (select_out[18] |-> !periph_write_out)
        else $error("reserved write forwarded");
    a_part_id_ro: assert property (select_out[2] |-> !periph_write_out)
        else $error("part id write forwarded");
    a_window_address: assert property (win |->
        global_addr_out == {flash_page_select_in[3:0], addr_in[13:0]})
        else $error("window address wrong");
    a_page_gap: assert property (page_missing_out ==
        (win && flash_page_select_in == 8'h0C && LARGE_FLASH == 0))
        else $error("missing page flag wrong");
    a_read_capture: assert property (read_in |=> last_read_out == $past(rdata_out))
        else $error("read not captured");
    c_reserved_write: cover property (write_in && select_out[18]);
    c_missing_page: cover property (page_missing_out);
    c_id_read: cover property (read_in && select_out[2]);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind register_space_address_decoder decoder_checker #(.LARGE_FLASH(LARGE_FLASH)) i_chk (.*);

//--- tb/periph_model.sv
// Behavioural peripheral registers standing behind the decoder's selects.
// Assumes the decoder's selects, gated write strobe and write data, one clock.
module periph_model (
    // Decoder side
    input wire logic clk_in,
    input wire logic [18:0] select_in,
    input wire logic write_in,
    input wire logic [7:0] wdata_in,
    output logic [151:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] reg_q [19];
    initial for (int i = 0; i < 19; i++) reg_q[i] = 8'h5A;
    always @(posedge clk_in) begin
        for (int i = 0; i < 19; i++)
            if (write_in && select_in[i]) reg_q[i] <= wdata_in;
    end
    // Unselected modules show inverted data so a loose read mux cannot pass
    always_comb begin
        for (int i = 0; i < 19; i++)
            rdata_out[8*i+:8] = select_in[i] ? reg_q[i] : ~reg_q[i];
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the register space decoder, small flash variant.
// Assumes the peripheral model answers behind every select.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID = 16'h3C71; // Arbitrary neutral value
    localparam logic [15:0] ADDRS [32] = '{16'h0000, 16'h0009, 16'h000A, 16'h000B,
        16'h000C, 16'h000E, 16'h0017, 16'h0018, 16'h001A, 16'h001B, 16'h001F, 16'h0033,
        16'h0034, 16'h003F, 16'h0040, 16'h006F, 16'h0070, 16'h009F, 16'h00A0, 16'h00C7,
        16'h00C8, 16'h00D0, 16'h00DF, 16'h00E0, 16'h0147, 16'h0150, 16'h0160, 16'h0177,
        16'h0178, 16'h0240, 16'h02F0, 16'h0300};
    localparam int SELS [32] = '{0, 0, 1, 1, 0, 18, 1, 18, 2, 2, 0, 18, 4, 4, 5, 5, 6, 6,
        7, 7, 8, 9, 10, 18, 13, 14, 15, 16, 18, 0, 4, 18};
    logic clk_in, rst_in, read_in, write_in, periph_write_out, page_missing_out;
    logic [15:0] addr_in;
    logic [7:0] wdata_in, flash_page_select_in, rdata_out, last_read_out, periph_wdata_out;
    logic [7:0] exp_q;
    logic [18:0] select_out;
    logic [151:0] periph_rdata_in;
    logic [17:0] global_addr_out;
    int bad_count = 0;
    int n_tests = 0;
    register_space_address_decoder #(.LARGE_FLASH(0), .PART_ID(ID)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .read_in(read_in),
        .write_in(write_in), .wdata_in(wdata_in), .flash_page_select_in(flash_page_select_in),
        .rdata_out(rdata_out), .select_out(select_out), .periph_write_out(periph_write_out),
        .periph_read_out(), .periph_wdata_out(periph_wdata_out),
        .periph_rdata_in(periph_rdata_in), .global_addr_out(global_addr_out),
        .page_missing_out(page_missing_out), .last_read_out(last_read_out));
    periph_model i_model (.clk_in(clk_in), .select_in(select_out),
        .write_in(periph_write_out), .wdata_in(periph_wdata_out), .rdata_out(periph_rdata_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(string what, logic [18:0] exp, logic [18:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One access per cycle; outputs are combinational, so look at mid-cycle
    task automatic acc(logic [15:0] a, logic rd, logic wr, logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        read_in <= rd;
        write_in <= wr;
        wdata_in <= d;
        @(negedge clk_in);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        {read_in, write_in, addr_in, wdata_in, flash_page_select_in} = '0;
        rst_in = 1;
        repeat (10) @(posedge clk_in);
        chk("reset capture", 0, last_read_out);
        rst_in <= 0;
        foreach (ADDRS[i]) begin
            exp_q = SELS[i] == 18 ? 8'h00 : SELS[i] != 2 ? ADDRS[i][7:0] ^ 8'hC3
                : ADDRS[i][0] ? ID[7:0] : ID[15:8];
            acc(ADDRS[i], 0, 1, ADDRS[i][7:0] ^ 8'hC3);
            chk("select", 19'h1 << SELS[i], select_out);
            chk("forwarded write", SELS[i] != 18 && SELS[i] != 2, periph_write_out);
            acc(ADDRS[i], 1, 0, 0);
            chk("read data", exp_q, rdata_out);
        end
        @(posedge clk_in);
        flash_page_select_in <= 8'h05;
        acc(16'h001B, 1, 0, 0);
        acc(16'h8123, 1, 0, 0);
        chk("captured read", ID[7:0], last_read_out);
        chk("global address", {4'h5, 14'h0123}, global_addr_out);
        @(posedge clk_in);
        flash_page_select_in <= 8'h0C;
        acc(16'hBFFF, 1, 0, 0);
        chk("missing page", 1, page_missing_out);
        chk("missing page data", 0, rdata_out);
        @(posedge clk_in);
        flash_page_select_in <= 8'h0B;
        acc(16'h8000, 0, 1, 8'h11);
        chk("present page", 0, page_missing_out);
        acc(16'h0500, 1, 0, 0);
        chk("outside map", 0, select_out);
        acc(16'h0000, 0, 0, 0);
        test_done;
    end
endmodule
